// ===== prog_port_pkg.sv
// Constants, types and command codes for the EPROM programming controller.
// Assumes a single 25 MHz clock and a programming socket wired to the pin ports.
// Summary of operation
// - Program: present data and address, then pulse program strobe low.
// - Read: chip select low, pulse output select low, byte appears on data.
// - Protect-verify reports the protect bit state to the programmer.
// - Order: erase, program, verify, then program and verify protect bit.
// - Unused locations should be programmed to zero for security.
// - 8K bytes addressed over 13 address lines.
package prog_port_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int SETUP_NS = 2000;
   localparam int HOLD_NS = 2000;
   localparam int PULSE_NS = 1000;
   localparam int ACCESS_NS = 200;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // ****************************************
   // Widths and fixed pin levels
   // ****************************************
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int PROTECT_BIT_POS = 7;
   localparam int PROTECT_SEL_ADDR_POS = 4;
   localparam int PROTECT_VFY_ADDR_POS = 6;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   typedef enum logic [2:0]
   {
      CMD_PROGRAM = 3'h0,
      CMD_VERIFY = 3'h1,
      CMD_READ = 3'h2,
      CMD_PROTECT = 3'h3,
      CMD_PROTECT_VERIFY = 3'h4
   } cmd_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_PULSE = 3'h2,
      ST_HOLD = 3'h3,
      ST_DONE = 3'h4
   } state_t;

   typedef struct packed
   {
      logic chip_sel_n;
      logic out_sel_n;
      logic program_strobe_n;
      logic vpp_en;
      logic test_mode_en;
      logic [ADDR_W-1:0] prog_addr_lines;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
   } pins_t;

   typedef struct packed
   {
      state_t state;
      cmd_t cmd;
      logic [CNT_W-1:0] cnt;
      pins_t pins;
      logic [DATA_W-1:0] rdata;
      logic done;
      logic match;
      logic locked;
   } ctrl_t;

endpackage

// ===== eprom_program_port.sv
// Programmer that drives the byte-wide EPROM programming pins of the target.
// Assumes the target clock and reset pins are strapped low on the socket.
`timescale 1ns/1ps
module eprom_program_port
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire prog_port_pkg::cmd_t req_cmd,
   input wire logic [prog_port_pkg::ADDR_W-1:0] req_addr,
   input wire logic [prog_port_pkg::DATA_W-1:0] req_data,
   output logic rsp_valid,
   output logic [prog_port_pkg::DATA_W-1:0] rsp_data,
   output logic rsp_match,
   output logic rsp_locked,
   output logic chip_sel_n,
   output logic out_sel_n,
   output logic program_strobe_n,
   output logic vpp_en,
   output logic test_mode_en,
   output logic [prog_port_pkg::ADDR_W-1:0] prog_addr_lines,
   input wire logic [prog_port_pkg::DATA_W-1:0] prog_data_lines_in,
   output logic [prog_port_pkg::DATA_W-1:0] prog_data_lines_out,
   output logic prog_data_lines_oe
);

   // ****************************************
   // Pin levels per operation
   // ****************************************
   function automatic prog_port_pkg::pins_t idle_pins();
      prog_port_pkg::pins_t p;
      p = '0;
      p.chip_sel_n = 1'b1;
      p.out_sel_n = 1'b1;
      p.program_strobe_n = 1'b1;
      return p;
   endfunction

   function automatic prog_port_pkg::pins_t op_pins(input prog_port_pkg::cmd_t c,
      input logic [prog_port_pkg::ADDR_W-1:0] a, input logic [prog_port_pkg::DATA_W-1:0] d);
      prog_port_pkg::pins_t p;
      p = idle_pins();
      p.prog_addr_lines = a;
      case (c)
         prog_port_pkg::CMD_PROGRAM:
         begin
            p.chip_sel_n = 1'b0;
            p.vpp_en = 1'b1;
            p.data_out = d;
            p.data_oe = 1'b1;
         end
         prog_port_pkg::CMD_VERIFY:
         begin
            p.chip_sel_n = 1'b0;
            p.vpp_en = 1'b1;
         end
         prog_port_pkg::CMD_READ:
         begin
            p.chip_sel_n = 1'b0;
         end
         prog_port_pkg::CMD_PROTECT:
         begin
            // Chip select stays high; only the protect pulse on the top data line programs.
            p.vpp_en = 1'b1;
            p.test_mode_en = 1'b1;
            p.prog_addr_lines = '0;
            p.prog_addr_lines[prog_port_pkg::PROTECT_SEL_ADDR_POS] = 1'b1;
            p.data_out = prog_port_pkg::ERASED_BYTE;
            p.data_oe = 1'b1;
         end
         prog_port_pkg::CMD_PROTECT_VERIFY:
         begin
            p.chip_sel_n = 1'b0;
            p.test_mode_en = 1'b1;
            p.prog_addr_lines = '0;
         end
         default:
         begin
            p = idle_pins();
         end
      endcase
      return p;
   endfunction

   // ****************************************
   // Sequencer
   // ****************************************
   prog_port_pkg::ctrl_t st_reg;
   prog_port_pkg::ctrl_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      case (st_reg.state)
         prog_port_pkg::ST_IDLE:
         begin
            st_next.pins = idle_pins();
            if (req_valid)
            begin
               st_next.cmd = req_cmd;
               st_next.pins = op_pins(req_cmd, req_addr, req_data);
               st_next.cnt = prog_port_pkg::CNT_W'(prog_port_pkg::SETUP_CYC);
               st_next.state = prog_port_pkg::ST_SETUP;
            end
         end
         prog_port_pkg::ST_SETUP:
         begin
            if (st_reg.cnt > prog_port_pkg::CNT_W'(1))
            begin
               st_next.cnt = st_reg.cnt - prog_port_pkg::CNT_W'(1);
            end
            else
            begin
               st_next.state = prog_port_pkg::ST_PULSE;
               case (st_reg.cmd)
                  prog_port_pkg::CMD_PROGRAM:
                  begin
                     st_next.pins.program_strobe_n = 1'b0;
                     st_next.cnt = prog_port_pkg::CNT_W'(prog_port_pkg::PULSE_CYC);
                  end
                  prog_port_pkg::CMD_PROTECT:
                  begin
                     // The protect bit is written by a low pulse on the top data line.
                     st_next.pins.data_out[prog_port_pkg::PROTECT_BIT_POS] = 1'b0;
                     st_next.cnt = prog_port_pkg::CNT_W'(prog_port_pkg::PULSE_CYC);
                  end
                  prog_port_pkg::CMD_PROTECT_VERIFY:
                  begin
                     st_next.pins.out_sel_n = 1'b0;
                     st_next.cnt = prog_port_pkg::CNT_W'(prog_port_pkg::ACCESS_CYC);
                  end
                  default:
                  begin
                     st_next.pins.out_sel_n = 1'b0;
                     st_next.cnt = prog_port_pkg::CNT_W'(prog_port_pkg::ACCESS_CYC);
                  end
               endcase
            end
         end
         prog_port_pkg::ST_PULSE:
         begin
            if (st_reg.cnt > prog_port_pkg::CNT_W'(1))
            begin
               st_next.cnt = st_reg.cnt - prog_port_pkg::CNT_W'(1);
            end
            else
            begin
               st_next.pins.program_strobe_n = 1'b1;
               st_next.pins.out_sel_n = 1'b1;
               st_next.pins.data_out[prog_port_pkg::PROTECT_BIT_POS] =
                  st_reg.pins.data_out[prog_port_pkg::PROTECT_BIT_POS] |
                  (st_reg.cmd == prog_port_pkg::CMD_PROTECT);
               st_next.cnt = prog_port_pkg::CNT_W'(prog_port_pkg::HOLD_CYC);
               st_next.state = prog_port_pkg::ST_HOLD;
               case (st_reg.cmd)
                  prog_port_pkg::CMD_PROGRAM, prog_port_pkg::CMD_PROTECT:
                  begin
                     st_next.rdata = st_reg.pins.data_out;
                  end
                  prog_port_pkg::CMD_PROTECT_VERIFY:
                  begin
                     st_next.rdata = prog_data_lines_in;
                     // A zero on the top line means the protect bit is programmed.
                     st_next.locked = ~prog_data_lines_in[prog_port_pkg::PROTECT_BIT_POS];
                  end
                  default:
                  begin
                     st_next.rdata = prog_data_lines_in;
                  end
               endcase
            end
         end
         prog_port_pkg::ST_HOLD:
         begin
            if (st_reg.cnt > prog_port_pkg::CNT_W'(1))
            begin
               st_next.cnt = st_reg.cnt - prog_port_pkg::CNT_W'(1);
            end
            else
            begin
               st_next.pins = idle_pins();
               st_next.state = prog_port_pkg::ST_DONE;
            end
         end
         prog_port_pkg::ST_DONE:
         begin
            // A read result is compared with the byte the caller expects.
            st_next.match = (st_reg.rdata == req_data);
            st_next.done = 1'b1;
            st_next.state = prog_port_pkg::ST_IDLE;
         end
         default:
         begin
            st_next.state = prog_port_pkg::ST_IDLE;
            st_next.pins = idle_pins();
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.pins.chip_sel_n <= 1'b1;
         st_reg.pins.out_sel_n <= 1'b1;
         st_reg.pins.program_strobe_n <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign req_ready = (st_reg.state == prog_port_pkg::ST_IDLE);
   assign rsp_valid = st_reg.done;
   assign rsp_data = st_reg.rdata;
   assign rsp_match = st_reg.match;
   assign rsp_locked = st_reg.locked;
   assign chip_sel_n = st_reg.pins.chip_sel_n;
   assign out_sel_n = st_reg.pins.out_sel_n;
   assign program_strobe_n = st_reg.pins.program_strobe_n;
   assign vpp_en = st_reg.pins.vpp_en;
   assign test_mode_en = st_reg.pins.test_mode_en;
   assign prog_addr_lines = st_reg.pins.prog_addr_lines;
   assign prog_data_lines_out = st_reg.pins.data_out;
   assign prog_data_lines_oe = st_reg.pins.data_oe;

endmodule

// ===== eprom_program_port_checker.sv
// Assertions on the pin and request ports of the EPROM programming controller.
// Assumes the 25 MHz timing constants of prog_port_pkg and a bind from the bench.
`timescale 1ns/1ps
module eprom_program_port_checker
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire prog_port_pkg::cmd_t req_cmd,
   input wire logic [prog_port_pkg::DATA_W-1:0] req_data,
   input wire logic rsp_valid,
   input wire logic [prog_port_pkg::DATA_W-1:0] rsp_data,
   input wire logic rsp_match,
   input wire logic chip_sel_n,
   input wire logic out_sel_n,
   input wire logic program_strobe_n,
   input wire logic vpp_en,
   input wire logic test_mode_en,
   input wire logic [prog_port_pkg::ADDR_W-1:0] prog_addr_lines,
   input wire logic [prog_port_pkg::DATA_W-1:0] prog_data_lines_out,
   input wire logic prog_data_lines_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_strobe_gated: assert property (!program_strobe_n |-> !chip_sel_n && vpp_en && out_sel_n)
      else $error("program strobe low without select or supply");
   a_strobe_width: assert property ($fell(program_strobe_n) |-> ##24 !program_strobe_n ##1 program_strobe_n)
      else $error("program pulse width wrong");
   a_data_held: assert property (!program_strobe_n |-> $stable(prog_addr_lines) && $stable(prog_data_lines_out))
      else $error("address or data moved during program pulse");
   a_read_select: assert property (!out_sel_n |-> !chip_sel_n && !prog_data_lines_oe)
      else $error("output select low without chip select or with data driven");
   a_read_latency: assert property (req_valid && req_ready && req_cmd == prog_port_pkg::CMD_READ |-> ##107 rsp_valid)
      else $error("read answer late or early");
   a_prog_latency: assert property (req_valid && req_ready && req_cmd == prog_port_pkg::CMD_PROGRAM |-> ##127 rsp_valid)
      else $error("program answer late or early");
   a_rsp_single: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer longer than one cycle");
   a_match_value: assert property (rsp_valid |-> rsp_match == (rsp_data == req_data))
      else $error("match flag disagrees with data");
   a_protect_pins: assert property (test_mode_en && prog_data_lines_oe && !prog_data_lines_out[7] |-> chip_sel_n && vpp_en && prog_addr_lines[4])
      else $error("protect pulse with wrong pin levels");
endmodule

// ===== eprom_cell_model.sv
// Behavioural model of the target's byte-wide EPROM cell and its protect bit.
// Assumes the bench resolves the shared data lines and sends the level back in dq.
`timescale 1ns/1ps
module eprom_cell_model
(
   input wire logic sys_clk,
   input wire logic erase,
   input wire logic chip_sel_n,
   input wire logic out_sel_n,
   input wire logic program_strobe_n,
   input wire logic vpp_en,
   input wire logic test_mode_en,
   input wire logic [12:0] addr,
   input wire logic [7:0] dq,
   output logic [7:0] q,
   output logic q_oe
);
   logic [7:0] mem [8192];
   logic protect_bit;

   // Programming runs every cycle the strobe is low; ANDing is idempotent so length is moot.
   always @(posedge sys_clk)
   begin
      if (erase)
      begin
         foreach (mem[i]) mem[i] <= 8'hff;
         protect_bit <= 1'b0;
      end
      else if (!chip_sel_n && !program_strobe_n && vpp_en && !test_mode_en)
         mem[addr] <= mem[addr] & dq;
      else if (chip_sel_n && test_mode_en && vpp_en && addr[4] && !dq[7])
         protect_bit <= 1'b1;
   end

   assign q_oe = !chip_sel_n && !out_sel_n && (test_mode_en || !protect_bit);
   // The protect bit gates only the output enable, so stored code stays usable inside.
   assign q = test_mode_en ? {~protect_bit, 7'h7f} : mem[addr];
endmodule

// ===== tb.sv
// Self-checking bench: controller against the EPROM cell model.
// Assumes nothing beyond the design, its package and the two files before it.
`timescale 1ns/1ps
module tb;
   typedef struct packed
   {
      prog_port_pkg::cmd_t cmd;
      logic [12:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
      logic [1:0] kind;
   } row_t;
   logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, uv_erase = 1'b1;
   prog_port_pkg::cmd_t req_cmd = prog_port_pkg::CMD_READ;
   logic [12:0] req_addr = 13'h0000, prog_addr_lines;
   logic [7:0] req_data = 8'h00, dq, dq_last = 8'h00, m_q, rsp_data, prog_data_lines_out;
   logic req_ready, rsp_valid, rsp_match, rsp_locked, chip_sel_n, out_sel_n, m_oe;
   logic program_strobe_n, vpp_en, test_mode_en, prog_data_lines_oe;
   int mismatches = 0, check_count = 0, cycles = 0;
   row_t rows [12] = '{
      '{prog_port_pkg::CMD_READ, 13'h0000, 8'h00, 8'hff, 2'h0},
      '{prog_port_pkg::CMD_PROGRAM, 13'h0000, 8'ha5, 8'ha5, 2'h0},
      '{prog_port_pkg::CMD_VERIFY, 13'h0000, 8'ha5, 8'h01, 2'h1},
      '{prog_port_pkg::CMD_PROGRAM, 13'h0000, 8'h0f, 8'h0f, 2'h0},
      '{prog_port_pkg::CMD_READ, 13'h0000, 8'h00, 8'h05, 2'h0},
      '{prog_port_pkg::CMD_PROGRAM, 13'h1fff, 8'h00, 8'h00, 2'h0},
      '{prog_port_pkg::CMD_READ, 13'h1fff, 8'h00, 8'h00, 2'h0},
      '{prog_port_pkg::CMD_READ, 13'h0001, 8'h00, 8'hff, 2'h0},
      '{prog_port_pkg::CMD_PROTECT_VERIFY, 13'h0000, 8'h00, 8'h00, 2'h2},
      '{prog_port_pkg::CMD_PROTECT, 13'h0000, 8'h00, 8'h00, 2'h2},
      '{prog_port_pkg::CMD_PROTECT_VERIFY, 13'h0000, 8'h00, 8'h01, 2'h2},
      '{prog_port_pkg::CMD_READ, 13'h0000, 8'h05, 8'h00, 2'h1}};

   // Floating lines keep bit 7 high and toggle the rest, so a blocked read cannot match.
   always_comb dq = m_oe ? m_q : (prog_data_lines_oe ? prog_data_lines_out : {1'b1, ~dq_last[6:0]});
   always #20 sys_clk = ~sys_clk;

   eprom_program_port i_eprom_program_port (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_match(rsp_match), .rsp_locked(rsp_locked),
      .chip_sel_n(chip_sel_n), .out_sel_n(out_sel_n), .program_strobe_n(program_strobe_n),
      .vpp_en(vpp_en), .test_mode_en(test_mode_en), .prog_addr_lines(prog_addr_lines),
      .prog_data_lines_in(dq), .prog_data_lines_out(prog_data_lines_out),
      .prog_data_lines_oe(prog_data_lines_oe));
   eprom_cell_model i_eprom_cell_model (.sys_clk(sys_clk), .erase(uv_erase), .chip_sel_n(chip_sel_n),
      .out_sel_n(out_sel_n), .program_strobe_n(program_strobe_n), .vpp_en(vpp_en),
      .test_mode_en(test_mode_en), .addr(prog_addr_lines), .dq(dq), .q(m_q), .q_oe(m_oe));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic do_op(input row_t r);
      int n;
      n = 0;
      @(posedge sys_clk);
      req_cmd <= r.cmd;
      req_addr <= r.addr;
      req_data <= r.data;
      req_valid <= 1'b1;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      do
      begin
         @(posedge sys_clk);
         #1 n++;
      end
      while (rsp_valid !== 1'b1 && n < 300);
      if (rsp_valid !== 1'b1)
      begin
         mismatches++;
         $display("mismatch at %0t: no answer to request", $time);
      end
      if (r.kind == 2'h0) check8(rsp_data, r.exp, "data");
      else if (r.kind == 2'h1) check8({7'h00, rsp_match}, r.exp, "match");
      else check8({7'h00, rsp_locked}, r.exp, "lock");
   endtask

   always @(posedge sys_clk)
   begin
      dq_last <= dq;
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         mismatches++;
         end_sim();
      end
   end

   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      uv_erase <= 1'b0;
      foreach (rows[i]) do_op(rows[i]);
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 check8({chip_sel_n, out_sel_n, program_strobe_n, prog_data_lines_oe, vpp_en, req_ready,
         2'b00}, 8'he4, "idle pins");
      @(posedge sys_clk) rst <= 1'b0;
      do_op(row_t'{prog_port_pkg::CMD_READ, 13'h0000, 8'h05, 8'h00, 2'h1});
      @(posedge sys_clk) uv_erase <= 1'b1;
      @(posedge sys_clk) uv_erase <= 1'b0;
      do_op(row_t'{prog_port_pkg::CMD_PROTECT_VERIFY, 13'h0000, 8'h00, 8'h00, 2'h2});
      do_op(row_t'{prog_port_pkg::CMD_READ, 13'h0000, 8'h00, 8'hff, 2'h0});
      end_sim();
   end
endmodule

bind eprom_program_port eprom_program_port_checker i_chk (.*);
